/* rtl/atcc_pkg.sv */
// constants and types shared by the converter trigger and compare control
package atcc_pkg;
    // ----------
    // register indices and byte addresses
    // ----------
    localparam int unsigned ATCC_ADDR_W = 12;
    localparam logic [7:0] ATCC_IDX_CTRL_ONE = 8'he1;
    localparam logic [7:0] ATCC_IDX_CTRL_TWO = 8'he2;
    localparam logic [7:0] ATCC_IDX_DELAY_LOW = 8'he3;
    localparam logic [7:0] ATCC_IDX_CTRL_ZERO = 8'he8;
    localparam logic [7:0] ATCC_IDX_THRESHOLD = 8'hf0;
    localparam logic [7:0] ATCC_IDX_RESULT = 8'hf1;

    // byte address is four times the index
    function automatic logic [ATCC_ADDR_W-1:0] atcc_byte_addr(input logic [7:0] idx);
        atcc_byte_addr = {2'h0, idx, 2'h0};
    endfunction

    // ----------
    // field positions
    // ----------
    localparam int unsigned ATCC_C0_DONE = 7;
    localparam int unsigned ATCC_C0_BUSY = 6;
    localparam int unsigned ATCC_C0_SRC_HI = 5;
    localparam int unsigned ATCC_C0_SRC_LO = 4;
    localparam int unsigned ATCC_C0_CH_HI = 3;
    localparam int unsigned ATCC_C0_CH_LO = 0;
    localparam int unsigned ATCC_C1_TYPE_HI = 3;
    localparam int unsigned ATCC_C1_TYPE_LO = 2;
    localparam int unsigned ATCC_C1_EXT_EN = 1;
    localparam int unsigned ATCC_C1_CONV_EN = 0;
    localparam int unsigned ATCC_C2_BRAKE_EN = 7;
    localparam int unsigned ATCC_C2_POL = 6;
    localparam int unsigned ATCC_C2_CMP_EN = 5;
    localparam int unsigned ATCC_C2_CMP_OUT = 4;
    localparam int unsigned ATCC_C2_DLY_MSB = 0;

    // ----------
    // widths, codes and reset values
    // ----------
    localparam int unsigned ATCC_RES_W = 12;
    localparam int unsigned ATCC_DLY_W = 9;
    localparam logic [7:0] ATCC_REG_RESET = 8'h00;
    localparam logic [3:0] ATCC_CH_LAST_VALID = 4'h8;
    localparam logic [ATCC_DLY_W-1:0] ATCC_DLY_ONE = 9'h001;
    localparam logic [1:0] ATCC_SRC_PWM0 = 2'h0;
    localparam logic [1:0] ATCC_SRC_PWM2 = 2'h1;
    localparam logic [1:0] ATCC_SRC_PWM4 = 2'h2;
    localparam logic [1:0] ATCC_SRC_PIN = 2'h3;
    localparam logic [1:0] ATCC_TYP_FALL = 2'h0;
    localparam logic [1:0] ATCC_TYP_RISE = 2'h1;
    localparam logic [1:0] ATCC_TYP_CENTRE = 2'h2;
    localparam logic [1:0] ATCC_TYP_END = 2'h3;

    typedef enum logic [1:0] {
        ATCC_IDLE,
        ATCC_DELAY,
        ATCC_CONVERT
    } atcc_state_t;
endpackage

/* rtl/atcc_top.sv */
// converter trigger, delay, start/done and result compare control with apb registers
//
// Behaviour
// [R01] brake enabled and compare output 1: assert brake, pulse pwm run clear
// [R02] brake holds until the pwm run bit is set again
// [R03] polarity 0: result >= threshold gives 1; polarity 1: result < threshold
// [R04] compare enable switches the result comparator on and off
// [R05] compare output read only, refreshed at each conversion completion; the code refreshes it only while compare enable is set
// [R06] delay is nine bits: low byte register plus bit 0 of control two
// [R07] external trigger waits delay converter clocks before conversion starts
// [R08] delay only used for external triggers; software starts start at once
// [R09] software must not change delay while pwm trigger source runs
// [R10] done flag set on completion; cleared only by software write
// [R11] done flag set blocks every new conversion start
// [R12] writing 1 to start/busy starts a conversion, writing 0 does nothing
// [R13] start/busy reads 1 while converting, cleared at completion
// [R14] source field picks pwm0, pwm2, pwm4 or the external start pin
// [R15] channel field picks inputs 0 to 7 or band-gap; others reserved
// [R16] converter disabled disconnects every analog input
// [R17] external triggers only when enabled; ignored while busy
// [R18] trigger type: falling, rising, pwm centre point, pwm end point
// [R19] converter enable powers the conversion circuit
// [R20] compare output holds between conversions; disabled comparator does nothing
// [R21] all bits reset to zero, converter idle, triggers off
`timescale 1ns/1ps
module atcc_top
    import atcc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ATCC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // analog converter core
    output logic o_conv_power,
    output logic o_conv_start,
    output logic [3:0] o_mux_channel,
    output logic o_mux_connect,
    input wire logic i_conv_done,
    input wire logic [ATCC_RES_W-1:0] i_conv_result,
    // trigger sources
    input wire logic i_pwm_out0,
    input wire logic i_pwm_out2,
    input wire logic i_pwm_out4,
    input wire logic i_external_start_pin,
    input wire logic i_pwm_centre_point,
    input wire logic i_pwm_end_point,
    // pwm generator fault brake
    input wire logic i_pwm_run_bit,
    output logic o_fault_brake,
    output logic o_pwm_run_clear
);
    // ----------
    // register state
    // ----------
    logic conversion_done_flag_q, start_busy_bit_q;
    logic [1:0] trigger_source_select_q, trigger_type_select_q;
    logic [3:0] input_channel_select_q;
    logic external_trigger_enable_q, converter_enable_q;
    logic compare_brake_enable_q, compare_polarity_q, compare_enable_q, compare_output_q;
    logic [ATCC_DLY_W-1:0] trigger_delay_count_q;
    logic [ATCC_RES_W-1:0] compare_threshold_q;
    logic [ATCC_RES_W-1:0] conversion_result_q;

    atcc_state_t state_q;
    logic [ATCC_DLY_W-1:0] delay_cnt_q;
    logic trig_level_q, pwm_run_q;

    // ----------
    // bus decode
    // ----------
    logic access, wr_en;
    logic hit_c0, hit_c1, hit_c2, hit_dly, hit_thr, hit_res, hit_any;

    // access completes on the edge where the registered ready is high
    assign access = i_psel & i_penable & o_pready;
    assign wr_en = access & i_pwrite;
    assign hit_c0 = (i_paddr == atcc_byte_addr(ATCC_IDX_CTRL_ZERO));
    assign hit_c1 = (i_paddr == atcc_byte_addr(ATCC_IDX_CTRL_ONE));
    assign hit_c2 = (i_paddr == atcc_byte_addr(ATCC_IDX_CTRL_TWO));
    assign hit_dly = (i_paddr == atcc_byte_addr(ATCC_IDX_DELAY_LOW));
    assign hit_thr = (i_paddr == atcc_byte_addr(ATCC_IDX_THRESHOLD));
    assign hit_res = (i_paddr == atcc_byte_addr(ATCC_IDX_RESULT));
    assign hit_any = hit_c0 | hit_c1 | hit_c2 | hit_dly | hit_thr | hit_res;

    // ----------
    // trigger detection and start decisions
    // ----------
    logic trig_level, ext_event, sw_start, can_start, ext_accept, go_now, cmp_result;

    // selected trigger pin
    always_comb begin
        unique case (trigger_source_select_q)
            ATCC_SRC_PWM0: trig_level = i_pwm_out0;
            ATCC_SRC_PWM2: trig_level = i_pwm_out2;
            ATCC_SRC_PWM4: trig_level = i_pwm_out4;
            ATCC_SRC_PIN: trig_level = i_external_start_pin;
        endcase
    end // see [R14]

    // event of the chosen type
    always_comb begin
        unique case (trigger_type_select_q)
            ATCC_TYP_FALL: ext_event = trig_level_q & ~trig_level;
            ATCC_TYP_RISE: ext_event = ~trig_level_q & trig_level;
            ATCC_TYP_CENTRE: ext_event = i_pwm_centre_point;
            ATCC_TYP_END: ext_event = i_pwm_end_point;
        endcase
    end // see [R18]

    // starts need a powered converter, no pending done flag and an idle core
    assign can_start = converter_enable_q & ~conversion_done_flag_q & (state_q != ATCC_CONVERT); // see [R11]
    assign sw_start = wr_en & hit_c0 & i_pwdata[ATCC_C0_BUSY] & can_start; // see [R12]
    assign ext_accept = external_trigger_enable_q & ext_event & can_start & (state_q == ATCC_IDLE); // see [R17]
    // delayed start fires when the counter runs out; zero delay fires at once
    assign go_now = sw_start
        | (ext_accept & (trigger_delay_count_q == '0))
        | ((state_q == ATCC_DELAY) & (delay_cnt_q == ATCC_DLY_ONE) & can_start); // see [R07]

    // comparator sense
    assign cmp_result = compare_polarity_q ? (i_conv_result < compare_threshold_q)
                                           : (i_conv_result >= compare_threshold_q); // see [R03]

    // ----------
    // conversion sequencer
    // ----------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ATCC_IDLE; // see [R21]
            delay_cnt_q <= '0;
        end else if (!converter_enable_q) begin
            state_q <= ATCC_IDLE;
            delay_cnt_q <= '0;
        end else if (go_now) begin
            state_q <= ATCC_CONVERT; // see [R08]
            delay_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ATCC_IDLE: begin
                    if (ext_accept) begin
                        state_q <= ATCC_DELAY;
                        delay_cnt_q <= trigger_delay_count_q; // see [R07]
                    end
                end
                ATCC_DELAY: begin
                    if (!external_trigger_enable_q || conversion_done_flag_q) begin
                        state_q <= ATCC_IDLE;
                    end else begin
                        delay_cnt_q <= delay_cnt_q - ATCC_DLY_ONE;
                    end
                end
                ATCC_CONVERT: begin
                    if (i_conv_done) begin
                        state_q <= ATCC_IDLE;
                    end
                end
            endcase
        end
    end

    // start pulse to the analog core
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= go_now & converter_enable_q;
        end
    end

    // previous trigger and run bit levels for edge detection
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trig_level_q <= 1'b0;
            pwm_run_q <= 1'b0;
        end else begin
            trig_level_q <= trig_level;
            pwm_run_q <= i_pwm_run_bit;
        end
    end

    // ----------
    // status bits: busy, done, result and compare output
    // ----------
    logic conv_complete;
    assign conv_complete = (state_q == ATCC_CONVERT) & i_conv_done;

    // busy reads 1 only while converting
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            start_busy_bit_q <= 1'b0;
        end else if (go_now && converter_enable_q) begin
            start_busy_bit_q <= 1'b1;
        end else if (conv_complete || !converter_enable_q) begin
            start_busy_bit_q <= 1'b0; // see [R13]
        end
    end

    // done flag: a completion in the same cycle as a software clear wins
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            conversion_done_flag_q <= 1'b0;
        end else if (conv_complete) begin
            conversion_done_flag_q <= 1'b1; // see [R10]
        end else if (wr_en && hit_c0 && !i_pwdata[ATCC_C0_DONE]) begin
            conversion_done_flag_q <= 1'b0; // see [R10]
        end
    end

    // result capture and comparator refresh
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            conversion_result_q <= '0;
            compare_output_q <= 1'b0;
        end else if (conv_complete) begin
            conversion_result_q <= i_conv_result;
            if (compare_enable_q) begin
                compare_output_q <= cmp_result; // see [R04] [R05] [R20]
            end
        end
    end

    // ----------
    // fault brake toward the pwm generator
    // ----------
    logic brake_trip, run_set;
    assign brake_trip = conv_complete & compare_enable_q & compare_brake_enable_q & cmp_result; // see [R01] [R20]
    assign run_set = i_pwm_run_bit & ~pwm_run_q;

    // brake latches until software sets the run bit again
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fault_brake <= 1'b0;
            o_pwm_run_clear <= 1'b0;
        end else begin
            o_pwm_run_clear <= brake_trip; // see [R01]
            if (brake_trip) begin
                o_fault_brake <= 1'b1; // see [R01]
            end else if (run_set) begin
                o_fault_brake <= 1'b0; // see [R02]
            end
        end
    end

    // ----------
    // control register writes
    // ----------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trigger_source_select_q <= ATCC_REG_RESET[1:0]; // see [R21]
            input_channel_select_q <= ATCC_REG_RESET[3:0];
            trigger_type_select_q <= ATCC_REG_RESET[1:0];
            external_trigger_enable_q <= 1'b0;
            converter_enable_q <= 1'b0;
            compare_brake_enable_q <= 1'b0;
            compare_polarity_q <= 1'b0;
            compare_enable_q <= 1'b0;
            trigger_delay_count_q <= '0;
            compare_threshold_q <= '0;
        end else if (wr_en) begin
            if (hit_c0) begin
                trigger_source_select_q <= i_pwdata[ATCC_C0_SRC_HI:ATCC_C0_SRC_LO];
                input_channel_select_q <= i_pwdata[ATCC_C0_CH_HI:ATCC_C0_CH_LO];
            end
            if (hit_c1) begin
                trigger_type_select_q <= i_pwdata[ATCC_C1_TYPE_HI:ATCC_C1_TYPE_LO];
                external_trigger_enable_q <= i_pwdata[ATCC_C1_EXT_EN];
                converter_enable_q <= i_pwdata[ATCC_C1_CONV_EN];
            end
            if (hit_c2) begin
                compare_brake_enable_q <= i_pwdata[ATCC_C2_BRAKE_EN];
                compare_polarity_q <= i_pwdata[ATCC_C2_POL];
                compare_enable_q <= i_pwdata[ATCC_C2_CMP_EN];
                trigger_delay_count_q[ATCC_DLY_W-1] <= i_pwdata[ATCC_C2_DLY_MSB]; // see [R06]
            end
            if (hit_dly) begin
                trigger_delay_count_q[ATCC_DLY_W-2:0] <= i_pwdata[ATCC_DLY_W-2:0]; // see [R06]
            end
            if (hit_thr) begin
                compare_threshold_q <= i_pwdata[ATCC_RES_W-1:0];
            end
        end
    end

    // ----------
    // analog power and input multiplexer
    // ----------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_conv_power <= 1'b0;
            o_mux_channel <= 4'h0;
            o_mux_connect <= 1'b0;
        end else begin
            o_conv_power <= converter_enable_q; // see [R19]
            o_mux_channel <= input_channel_select_q; // see [R15]
            o_mux_connect <= converter_enable_q & (input_channel_select_q <= ATCC_CH_LAST_VALID); // see [R16]
        end
    end

    // ----------
    // apb answer: one wait state, registered data and error
    // ----------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_c0) begin
            rd_mux[7:0] = {conversion_done_flag_q, start_busy_bit_q, trigger_source_select_q, input_channel_select_q};
        end else if (hit_c1) begin
            rd_mux[7:0] = {4'h0, trigger_type_select_q, external_trigger_enable_q, converter_enable_q};
        end else if (hit_c2) begin
            rd_mux[7:0] = {compare_brake_enable_q, compare_polarity_q, compare_enable_q, compare_output_q,
                           3'h0, trigger_delay_count_q[ATCC_DLY_W-1]};
        end else if (hit_dly) begin
            rd_mux[7:0] = trigger_delay_count_q[ATCC_DLY_W-2:0];
        end else if (hit_thr) begin
            rd_mux[ATCC_RES_W-1:0] = compare_threshold_q;
        end else if (hit_res) begin
            rd_mux[ATCC_RES_W-1:0] = conversion_result_q;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel & i_penable & ~o_pready;
            o_prdata <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_mux : 32'h0000_0000;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~hit_any;
        end
    end
endmodule

/* verif/atcc_top_chk.sv */
// assertion checker for the converter trigger and compare control
`timescale 1ns/1ps
module atcc_top_chk
    import atcc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ATCC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // converter core
    input wire logic o_conv_power,
    input wire logic o_conv_start,
    input wire logic [3:0] o_mux_channel,
    input wire logic o_mux_connect,
    input wire logic i_conv_done,
    input wire logic [ATCC_RES_W-1:0] i_conv_result,
    // trigger sources
    input wire logic i_pwm_out0,
    input wire logic i_pwm_out2,
    input wire logic i_pwm_out4,
    input wire logic i_external_start_pin,
    input wire logic i_pwm_centre_point,
    input wire logic i_pwm_end_point,
    // fault brake
    input wire logic i_pwm_run_bit,
    input wire logic o_fault_brake,
    input wire logic o_pwm_run_clear
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ----------
    // bus answers
    // ----------
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("bus answer late");
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("bus answer too long");
    a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("error outside answer");
    a_rdata_idle: assert property (!(o_pready && !i_pwrite) |-> o_prdata == 32'h0) else $error("stray read data");
    // ----------
    // conversion, input selection and brake
    // ----------
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
    a_mux_gated: assert property (o_mux_connect |-> o_conv_power && o_mux_channel <= 4'h8)
        else $error("input connected wrongly");
    a_brake_cause: assert property ($rose(o_fault_brake) |-> $past(i_conv_done) && o_pwm_run_clear)
        else $error("brake without cause");
    a_brake_hold: assert property (o_fault_brake && !$rose(i_pwm_run_bit) |=> o_fault_brake)
        else $error("brake dropped early");
    a_brake_release: assert property (o_fault_brake && $rose(i_pwm_run_bit) |=> !o_fault_brake)
        else $error("brake not released");
    c_brake: cover property (o_pwm_run_clear);
    c_refused: cover property (o_pslverr);
    c_start: cover property (o_conv_start);
endmodule

bind atcc_top atcc_top_chk u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_conv_power(o_conv_power), .o_conv_start(o_conv_start), .o_mux_channel(o_mux_channel),
    .o_mux_connect(o_mux_connect), .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
    .i_pwm_out0(i_pwm_out0), .i_pwm_out2(i_pwm_out2), .i_pwm_out4(i_pwm_out4),
    .i_external_start_pin(i_external_start_pin), .i_pwm_centre_point(i_pwm_centre_point),
    .i_pwm_end_point(i_pwm_end_point), .i_pwm_run_bit(i_pwm_run_bit), .o_fault_brake(o_fault_brake),
    .o_pwm_run_clear(o_pwm_run_clear)
);

/* verif/atcc_far_model.sv */
// far-side model: converter core answering starts, and the pwm generator run bit
`timescale 1ns/1ps
module atcc_far_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // converter core
    input wire logic i_conv_start,
    input wire logic [7:0] i_latency,
    input wire logic [11:0] i_result,
    output logic o_conv_done,
    output logic [11:0] o_conv_result,
    // pwm generator
    input wire logic i_run_clear,
    input wire logic i_run_cmd,
    output logic o_pwm_run_bit
);
    logic [7:0] count_q;
    logic cmd_q;
    // done pulse after the latency; the result bus toggles whenever it is not valid
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_q <= 8'h00;
            o_conv_done <= 1'b0;
            o_conv_result <= 12'h000;
        end else begin
            o_conv_done <= 1'b0;
            o_conv_result <= ~o_conv_result;
            if (i_conv_start) begin
                count_q <= i_latency;
            end else if (count_q == 8'h01) begin
                count_q <= 8'h00;
                o_conv_done <= 1'b1;
                o_conv_result <= i_result;
            end else if (count_q != 8'h00) begin
                count_q <= count_q - 8'h01;
            end
        end
    end
    // run bit: cleared on the brake request or a stop, set again on a run command edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cmd_q <= 1'b0;
            o_pwm_run_bit <= 1'b0;
        end else begin
            cmd_q <= i_run_cmd;
            if (i_run_clear || !i_run_cmd) begin
                o_pwm_run_bit <= 1'b0;
            end else if (!cmd_q) begin
                o_pwm_run_bit <= 1'b1;
            end
        end
    end
endmodule

/* verif/tb.sv */
// self-checking testbench for the converter trigger and compare control
`timescale 1ns/1ps
module tb;
    import atcc_pkg::*;
    // ----------
    // stimulus, outputs and bookkeeping
    // ----------
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_cmd = 1'b0;
    logic [11:0] paddr = 12'h000, res = 12'h000, result, r;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] trig = 4'h0, chan;
    logic [1:0] pt = 2'h0;
    logic [7:0] lat = 8'h08;
    logic [8:0] dly;
    logic pready, pslverr, power, start, connect, done, brake, run_clear, run, hit, en, lvl;
    logic [7:0] ridx[4] = '{8'he1, 8'he2, 8'he3, 8'he8};
    logic [32:0] apb_q[$];
    int start_q[$];
    int num_errors = 0, cmp_count = 0, cyc = 0, seed = 76, typ, src;
    atcc_top uut (
        .i_clock(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_conv_power(power), .o_conv_start(start), .o_mux_channel(chan), .o_mux_connect(connect),
        .i_conv_done(done), .i_conv_result(result), .i_pwm_out0(trig[0]), .i_pwm_out2(trig[1]),
        .i_pwm_out4(trig[2]), .i_external_start_pin(trig[3]), .i_pwm_centre_point(pt[0]),
        .i_pwm_end_point(pt[1]), .i_pwm_run_bit(run), .o_fault_brake(brake), .o_pwm_run_clear(run_clear)
    );
    atcc_far_model far (
        .i_clock(clk), .i_rst(rst), .i_conv_start(start), .i_latency(lat), .i_result(res),
        .o_conv_done(done), .o_conv_result(result), .i_run_clear(run_clear), .i_run_cmd(run_cmd),
        .o_pwm_run_bit(run)
    );
    // clock, 10 ns period
    always #5 clk = ~clk;
    task automatic fail(input string m);
        num_errors++;
        $display("unexpected %0t: %s", $time, m);
    endtask
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one bus transfer; notes the expected answer and, for a start, the start cycle
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] exp,
                       input logic st);
        int n;
        apb_q.push_back(wr ? {exp[32], 32'h0} : exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (st) start_q.push_back(cyc + 1);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail("bus hang");
            final_report();
        end else begin
            @(posedge clk);
        end
    endtask
    // waits for the converter core to finish, bounded
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 400);
        if (n >= 400) begin
            fail("no conversion");
            final_report();
        end else begin
            @(posedge clk);
        end
    endtask
    // ----------
    // monitor: compares answers and start pulses with the oldest note
    // ----------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pready === 1'b1) begin
            cmp_count++;
            if (apb_q.size() == 0 || {pslverr, prdata} !== apb_q.pop_front()) fail("bus answer");
        end
        if (start === 1'b1) begin
            cmp_count++;
            if (start_q.size() == 0 || cyc !== start_q.pop_front()) fail("conversion start");
        end
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (ridx[i]) apb(1'b0, ridx[i], 32'h0, 33'h0, 1'b0);
        apb(1'b1, 8'he4, 32'hff, {1'b1, 32'h0}, 1'b0);
        apb(1'b0, 8'he4, 32'h0, {1'b1, 32'h0}, 1'b0);
        // input selection over every channel code, then converter off
        apb(1'b1, 8'he1, 32'h1, 33'h0, 1'b0);
        for (int c = 0; c < 17; c++) begin
            if (c == 16) apb(1'b1, 8'he1, 32'h0, 33'h0, 1'b0);
            else apb(1'b1, 8'he8, 32'(c), 33'h0, 1'b0);
            @(posedge clk);
            cmp_count++;
            if (connect !== (c < 9) || chan !== 4'(c > 15 ? 15 : c) || power !== (c < 16)) fail("select");
        end
        // software starts with a delay loaded, compare polarity and brake
        apb(1'b1, 8'he1, 32'h3, 33'h0, 1'b0);
        apb(1'b1, 8'he3, 32'h20, 33'h0, 1'b0);
        apb(1'b1, 8'hf0, 32'h800, 33'h0, 1'b0);
        run_cmd <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            en = (k != 7);
            r = (k < 2) ? 12'h800 : (k < 4) ? 12'h7ff : 12'($random(seed));
            res <= r;
            hit = en ? (k[0] ? r < 12'h800 : r >= 12'h800) : hit;
            apb(1'b1, 8'he2, {24'h0, 1'b1, k[0], en, 5'h0}, 33'h0, 1'b0);
            apb(1'b1, 8'he8, 32'h40, 33'h0, 1'b1);
            apb(1'b0, 8'he8, 32'h0, 33'h40, 1'b0);
            wait_done();
            apb(1'b0, 8'he8, 32'h0, 33'h80, 1'b0);
            apb(1'b0, 8'he2, 32'h0, {25'h0, 1'b1, k[0], en, hit, 4'h0}, 1'b0);
            apb(1'b0, 8'hf1, 32'h0, {21'h0, r}, 1'b0);
            apb(1'b1, 8'he8, 32'h40, 33'h0, 1'b0);
            apb(1'b1, 8'he8, 32'h0, 33'h0, 1'b0);
            cmp_count++;
            if (brake !== (en & hit)) fail("brake");
            run_cmd <= 1'b0;
            @(posedge clk);
            run_cmd <= 1'b1;
            repeat (3) @(posedge clk);
            cmp_count++;
            if (brake !== 1'b0) fail("brake release");
        end
        // external triggers: every source with both edges, then the pwm points
        run_cmd <= 1'b0;
        lat <= 8'h02;
        for (int k = 0; k < 10; k++) begin
            typ = (k < 8) ? k % 2 : k - 6;
            src = k / 2 % 4;
            dly = (k == 3) ? 9'h101 : 9'($random(seed) & 31);
            lvl = (typ == 0);
            trig <= {4{lvl}};
            apb(1'b1, 8'he3, {24'h0, dly[7:0]}, 33'h0, 1'b0);
            apb(1'b1, 8'he2, {31'h0, dly[8]}, 33'h0, 1'b0);
            apb(1'b1, 8'he8, 32'(src * 16), 33'h0, 1'b0);
            apb(1'b1, 8'he1, 32'(typ * 4 + 3), 33'h0, 1'b0);
            if (typ < 2) begin
                trig[(src + 1) % 4] <= ~lvl;
                repeat (3) @(posedge clk);
                trig[src] <= ~lvl;
            end else begin
                pt[typ - 2] <= 1'b1;
            end
            start_q.push_back(cyc + dly + 2);
            @(posedge clk);
            pt <= 2'h0;
            wait_done();
            apb(1'b1, 8'he1, 32'h1, 33'h0, 1'b0);
            apb(1'b1, 8'he8, 32'h0, 33'h0, 1'b0);
        end
        cmp_count++;
        if (apb_q.size() != 0 || start_q.size() != 0) fail("missing answer");
        final_report();
    end
endmodule
